/* File: hdl/duhb_cfg.svh */
`ifndef DUHB_CFG_SVH
`define DUHB_CFG_SVH
// Prescaler divide codes
`define DUHB_DIV_BY_1        2'h0
`define DUHB_DIV_BY_4        2'h3
// Position of the override bit in the per-register byte
`define DUHB_OVERRIDE_POS    7
// Register index that holds the override bit
`define DUHB_OVERRIDE_REG    3'h4
// Register reset value
`define DUHB_REG_RESET       8'h00
// Least reset pulse, ns, and clock period, ns
`define DUHB_RESET_MIN_NS    40
`define DUHB_CLK_PERIOD_NS   100
// Least reset cycles, rounded up, at least one
`define DUHB_RESET_MIN_CYC   ((`DUHB_RESET_MIN_NS + `DUHB_CLK_PERIOD_NS - 1) / `DUHB_CLK_PERIOD_NS)
`endif

/* File: hdl/duhb_pkg.sv */
package duhb_pkg;
  // Bus access request seen by the core
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } duhb_req_t;

  // Per-channel register file
  typedef logic [7:0][7:0] duhb_regs_t;

  // Access phase, Gray coded
  typedef enum logic [1:0] {
    DUHB_IDLE = 2'b00,
    DUHB_RD   = 2'b01,
    DUHB_WR   = 2'b11
  } duhb_phase_t;

  // All module state
  typedef struct packed {
    logic [2:0]  rd_n_s;
    logic [2:0]  wr_n_s;
    logic [2:0]  csa_n_s;
    logic [2:0]  csb_n_s;
    logic [2:0]  chan_s;
    logic [2:0]  rst_s;
    logic [2:0]  iso_s;
    logic [2:0]  strap_s;
    logic [2:0]  style_s;
    duhb_phase_t phase;
    logic [1:0]  sel;
    duhb_regs_t  regs_a;
    duhb_regs_t  regs_b;
    logic        strap_div1;
    logic [7:0]  rdata;
    logic        rdata_oe;
    logic        in_reset;
    logic [1:0]  prescale_a;
    logic [1:0]  prescale_b;
  } duhb_state_t;
endpackage

/* File: hdl/duhb_host_port.sv */
`timescale 1ns/100ps
`default_nettype none
`include "duhb_cfg.svh"

module duhb_host_port (
  input  wire logic       clock_i,           // 10 MHz clock
  input  wire logic       rst_b_i,           // Synchronous reset, active low
  input  wire logic       clk_en_i,          // Clock enable
  input  wire logic       bus_style_i,       // High strobe style, low line style
  input  wire logic       prescaler_strap_i, // Prescaler strap pin
  input  wire logic       reset_pin_i,       // Device reset pin, polarity by style
  input  wire logic       bus_isolate_i,     // Active-high bus isolation
  input  wire logic       read_strobe_n_i,   // Read strobe, or direction line (high read)
  input  wire logic       write_strobe_n_i,  // Write strobe, unused in line style
  input  wire logic       chan_a_select_n_i, // Channel A select, or common select
  input  wire logic       chan_b_select_n_i, // Channel B select, unused in line style
  input  wire logic       channel_addr_bit_i,// Channel address bit, line style
  input  wire logic [2:0] addr_i,            // Register address
  input  wire logic [7:0] data_i,            // Host data in
  input  wire logic [1:0] rx_i,              // Serial receive inputs
  output logic      [7:0] data_o,            // Host read data
  output logic            data_oe_o,         // High while driving data bus
  output logic      [1:0] tx_o,              // Serial transmit outputs
  output logic      [1:0] prescale_a_o,      // Channel A prescaler code
  output logic      [1:0] prescale_b_o,      // Channel B prescaler code
  output logic            in_reset_o,        // Device reset active
  output logic      [1:0] rx_seen_o          // Receive inputs as seen by core
);

  duhb_pkg::duhb_state_t s_q;
  duhb_pkg::duhb_state_t s_d;
  duhb_pkg::duhb_req_t   req;
  logic                  style_strobe;
  logic                  dev_rst;
  logic                  isolate;
  logic                  csa;
  logic                  csb;
  logic                  line_rd;

  // ************************************
  // Input decode from settled pins
  // ************************************
  always_comb begin
    style_strobe = s_q.style_s[2];
    dev_rst = style_strobe ? s_q.rst_s[2] : ~s_q.rst_s[2];
    isolate = s_q.iso_s[2];
    line_rd = s_q.rd_n_s[2];
    if (style_strobe) begin
      csa = ~s_q.csa_n_s[2];
      csb = ~s_q.csb_n_s[2];
    end else begin
      csa = ~s_q.csa_n_s[2] & ~s_q.chan_s[2];
      csb = ~s_q.csa_n_s[2] & s_q.chan_s[2];
    end
    req.addr  = addr_i;
    req.wdata = data_i;
    if (style_strobe) begin
      req.rd = ~s_q.rd_n_s[2];
      req.wr = ~s_q.wr_n_s[2];
    end else begin
      req.rd = line_rd;
      req.wr = ~line_rd;
    end
    if (isolate || dev_rst || !(csa || csb)) begin
      req.rd = 1'b0;
      req.wr = 1'b0;
    end
  end

  // ************************************
  // Next-state logic
  // ************************************
  always_comb begin
    s_d = s_q;
    // Three-stage pin synchronisers, change accepted when stages 0 and 1 agree
    s_d.rd_n_s[1:0]  = {s_q.rd_n_s[0], read_strobe_n_i};
    s_d.wr_n_s[1:0]  = {s_q.wr_n_s[0], write_strobe_n_i};
    s_d.csa_n_s[1:0] = {s_q.csa_n_s[0], chan_a_select_n_i};
    s_d.csb_n_s[1:0] = {s_q.csb_n_s[0], chan_b_select_n_i};
    s_d.chan_s[1:0]  = {s_q.chan_s[0], channel_addr_bit_i};
    s_d.rst_s[1:0]   = {s_q.rst_s[0], reset_pin_i};
    s_d.iso_s[1:0]   = {s_q.iso_s[0], bus_isolate_i};
    s_d.strap_s[1:0] = {s_q.strap_s[0], prescaler_strap_i};
    s_d.style_s[1:0] = {s_q.style_s[0], bus_style_i};
    if (s_q.rd_n_s[1] == s_q.rd_n_s[0]) s_d.rd_n_s[2] = s_q.rd_n_s[1];
    if (s_q.wr_n_s[1] == s_q.wr_n_s[0]) s_d.wr_n_s[2] = s_q.wr_n_s[1];
    if (s_q.csa_n_s[1] == s_q.csa_n_s[0]) s_d.csa_n_s[2] = s_q.csa_n_s[1];
    if (s_q.csb_n_s[1] == s_q.csb_n_s[0]) s_d.csb_n_s[2] = s_q.csb_n_s[1];
    if (s_q.chan_s[1] == s_q.chan_s[0]) s_d.chan_s[2] = s_q.chan_s[1];
    if (s_q.rst_s[1] == s_q.rst_s[0]) s_d.rst_s[2] = s_q.rst_s[1];
    if (s_q.iso_s[1] == s_q.iso_s[0]) s_d.iso_s[2] = s_q.iso_s[1];
    if (s_q.strap_s[1] == s_q.strap_s[0]) s_d.strap_s[2] = s_q.strap_s[1];
    if (s_q.style_s[1] == s_q.style_s[0]) s_d.style_s[2] = s_q.style_s[1];

    s_d.in_reset = dev_rst;
    s_d.rdata_oe = 1'b0;
    if (dev_rst) begin
      s_d.regs_a = {8{`DUHB_REG_RESET}};
      s_d.regs_b = {8{`DUHB_REG_RESET}};
      s_d.phase  = duhb_pkg::DUHB_IDLE;
      s_d.rdata  = 8'h00;
      s_d.strap_div1 = s_q.strap_s[2];
    end else begin
      unique case (s_q.phase)
        duhb_pkg::DUHB_IDLE: begin
          if (req.wr) begin
            s_d.phase = duhb_pkg::DUHB_WR;
            s_d.sel   = {csb, csa};
            if (csa) s_d.regs_a[req.addr] = req.wdata;
            if (csb) s_d.regs_b[req.addr] = req.wdata;
          end else if (req.rd) begin
            s_d.phase = duhb_pkg::DUHB_RD;
            s_d.sel   = {csb, csa};
          end
        end
        duhb_pkg::DUHB_RD: begin
          if (!req.rd) s_d.phase = duhb_pkg::DUHB_IDLE;
        end
        duhb_pkg::DUHB_WR: begin
          if (!req.wr) s_d.phase = duhb_pkg::DUHB_IDLE;
        end
        default: s_d.phase = duhb_pkg::DUHB_IDLE;
      endcase
      if (req.rd) begin
        s_d.rdata_oe = 1'b1;
        s_d.rdata    = csa ? s_q.regs_a[req.addr] : s_q.regs_b[req.addr];
      end
    end
    s_d.prescale_a = (s_q.strap_div1 && !s_q.regs_a[`DUHB_OVERRIDE_REG][`DUHB_OVERRIDE_POS])
                     ? `DUHB_DIV_BY_1 : `DUHB_DIV_BY_4;
    s_d.prescale_b = (s_q.strap_div1 && !s_q.regs_b[`DUHB_OVERRIDE_REG][`DUHB_OVERRIDE_POS])
                     ? `DUHB_DIV_BY_1 : `DUHB_DIV_BY_4;
  end

  // ************************************
  // State register
  // ************************************
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      s_q            <= '0;
      s_q.rd_n_s     <= 3'h7;
      s_q.wr_n_s     <= 3'h7;
      s_q.csa_n_s    <= 3'h7;
      s_q.csb_n_s    <= 3'h7;
      s_q.in_reset   <= 1'b1;
      s_q.prescale_a <= `DUHB_DIV_BY_4;
      s_q.prescale_b <= `DUHB_DIV_BY_4;
    end else if (clk_en_i) begin
      s_q <= s_d;
    end
  end

  // ************************************
  // Outputs from flip-flops, except tx_o tied high and rx_seen_o passing rx_i outside reset
  // ************************************
  assign data_o       = s_q.rdata;
  assign data_oe_o    = s_q.rdata_oe;
  assign prescale_a_o = s_q.prescale_a;
  assign prescale_b_o = s_q.prescale_b;
  assign in_reset_o   = s_q.in_reset;
  assign tx_o         = 2'h3;
  assign rx_seen_o    = s_q.in_reset ? 2'h3 : rx_i;

endmodule // duhb_host_port
`default_nettype wire

/* File: bench/duhb_host_port_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
// Port checks of the host bus front end
module duhb_host_port_asserts (
  input wire logic       clock_i,           // Clock
  input wire logic       rst_b_i,           // Reset
  input wire logic       bus_style_i,       // Style
  input wire logic       reset_pin_i,       // Reset pin
  input wire logic       bus_isolate_i,     // Isolate
  input wire logic       chan_a_select_n_i, // Select A
  input wire logic       chan_b_select_n_i, // Select B
  input wire logic       data_oe_o,         // Read drive
  input wire logic [1:0] tx_o,              // Transmit
  input wire logic       in_reset_o,        // In reset
  input wire logic [1:0] rx_seen_o          // Receive seen
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  // Pin conditions held past the synchronisers
  sequence s_rst_hi; (bus_style_i && reset_pin_i)[*6]; endsequence
  sequence s_rst_lo; (!bus_style_i && !reset_pin_i)[*6]; endsequence
  sequence s_off_st; (bus_style_i && chan_a_select_n_i && chan_b_select_n_i)[*8]; endsequence
  sequence s_off_ln; (!bus_style_i && chan_a_select_n_i)[*8]; endsequence
  sequence s_iso; bus_isolate_i[*8]; endsequence
  sequence s_rst; in_reset_o ##1 in_reset_o; endsequence
  property p_tx_idle; s_rst |-> tx_o == 2'h3; endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("transmit not idle in reset");
  property p_rx_mask; s_rst |-> rx_seen_o == 2'h3; endproperty
  a_rx_mask: assert property (p_rx_mask) else $error("receive not ignored in reset");
  property p_oe_rst; s_rst |-> !data_oe_o; endproperty
  a_oe_rst: assert property (p_oe_rst) else $error("bus driven in reset");
  property p_rst_hi; s_rst_hi |-> in_reset_o; endproperty
  a_rst_hi: assert property (p_rst_hi) else $error("high reset not taken");
  property p_rst_lo; s_rst_lo |-> in_reset_o; endproperty
  a_rst_lo: assert property (p_rst_lo) else $error("low reset not taken");
  property p_off_st; s_off_st |-> !data_oe_o; endproperty
  a_off_st: assert property (p_off_st) else $error("driven while deselected");
  property p_off_ln; s_off_ln |-> !data_oe_o; endproperty
  a_off_ln: assert property (p_off_ln) else $error("driven with select high");
  property p_iso; s_iso |-> !data_oe_o; endproperty
  a_iso: assert property (p_iso) else $error("driven while isolated");
endmodule // duhb_host_port_asserts
bind duhb_host_port duhb_host_port_asserts u_duhb_host_port_asserts (.clock_i, .rst_b_i, .bus_style_i,
  .reset_pin_i, .bus_isolate_i, .chan_a_select_n_i, .chan_b_select_n_i, .data_oe_o, .tx_o, .in_reset_o, .rx_seen_o);
`default_nettype wire

/* File: bench/duhb_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Host processor on the asynchronous parallel bus
module duhb_host_model (
  input  wire logic       clock_i, // Clock
  output var  logic       rd_n_o,  // Read strobe or direction
  output var  logic       wr_n_o,  // Write strobe
  output var  logic       csa_n_o, // Select A or common
  output var  logic       csb_n_o, // Select B
  output var  logic       chan_o,  // Channel bit
  output var  logic [2:0] addr_o,  // Register index
  output var  logic [7:0] data_o   // Write data
);
  // Idle bus at time zero
  initial begin
    {rd_n_o, wr_n_o, csa_n_o, csb_n_o, chan_o, addr_o, data_o} = 16'hF800;
  end
  // One access: drive, hold, release, settle
  task automatic xfer(input logic st, input logic [1:0] ch, input logic w, input logic [2:0] a, input logic [7:0] d);
    @(negedge clock_i);
    {addr_o, data_o, chan_o} = {a, d, ch[1]};
    if (st) {rd_n_o, wr_n_o, csa_n_o, csb_n_o} = {w, !w, !ch[0], !ch[1]};
    else {rd_n_o, csa_n_o} = {!w, 1'b0};
    repeat (8) @(negedge clock_i);
    {wr_n_o, csa_n_o, csb_n_o, data_o} = {3'h7, ~d};
    repeat (8) @(negedge clock_i);
    rd_n_o = 1'b1;
  endtask
endmodule // duhb_host_model
`default_nettype wire

/* File: bench/tb_dual_uart_host_bus_select.sv */
`timescale 1ns/100ps
`default_nettype none
`include "duhb_cfg.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; $display("wrong value at %0t: %h vs %h", $time, a, e); end end
module tb_dual_uart_host_bus_select;
  logic        clock_i = 1'b0, rst_b_i = 1'b0, style = 1'b1, strap = 1'b1, rpin = 1'b0, iso = 1'b0, oe_q = 1'b0;
  logic        rd_n, wr_n, csa_n, csb_n, chan, data_oe_o, in_reset_o;
  logic [2:0]  addr;
  logic [7:0]  hdata, data_o, va [8], vb [8], expq [$];
  logic [1:0]  rx = 2'h0, tx_o, pa, pb, rx_seen_o;
  logic [31:0] r = 32'hA9E817B0;
  int          n_tests = 0, n_mismatch = 0;
  // Clock, 100 ns period
  always #50 clock_i = !clock_i;
  duhb_host_model u_duhb_host_model (.clock_i, .rd_n_o(rd_n), .wr_n_o(wr_n), .csa_n_o(csa_n), .csb_n_o(csb_n),
    .chan_o(chan), .addr_o(addr), .data_o(hdata));
  duhb_host_port u_duhb_host_port (.clock_i, .rst_b_i, .clk_en_i(1'b1), .bus_style_i(style), .prescaler_strap_i(strap),
    .reset_pin_i(rpin), .bus_isolate_i(iso), .read_strobe_n_i(rd_n), .write_strobe_n_i(wr_n), .chan_a_select_n_i(csa_n),
    .chan_b_select_n_i(csb_n), .channel_addr_bit_i(chan), .addr_i(addr), .data_i(hdata), .rx_i(rx), .data_o,
    .data_oe_o, .tx_o, .prescale_a_o(pa), .prescale_b_o(pb), .in_reset_o, .rx_seen_o);
  // Each new read drive against the oldest note
  always @(negedge clock_i) begin
    if (data_oe_o === 1'b1 && oe_q === 1'b0) `CHK(data_o, expq.pop_front())
    oe_q = data_oe_o;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // One host access; a read leaves its expected byte
  task automatic acc(input logic [1:0] ch, input logic [2:0] a, input logic w, input logic [7:0] d);
    if (!w) expq.push_back(d);
    u_duhb_host_model.xfer(style, ch, w, a, d);
  endtask
  // Pin reset, polarity by style, strap caught meanwhile
  task automatic dev_rst(input logic s, input logic st);
    @(negedge clock_i);
    {style, strap, rpin, rx} = {s, st, s, 2'h0};
    repeat (8) @(negedge clock_i);
    `CHK(in_reset_o, 1'b1)
    `CHK({tx_o, rx_seen_o}, 4'hF)
    rpin = !s;
    repeat (8) @(negedge clock_i);
    `CHK(in_reset_o, 1'b0)
    `CHK({pa, pb}, st ? {2{`DUHB_DIV_BY_1}} : {2{`DUHB_DIV_BY_4}})
    $display("reset test done");
  endtask
  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (10) @(negedge clock_i);
    rst_b_i = 1'b1;
    dev_rst(1'b1, 1'b1);
    strap = 1'b0;
    for (int i = 0; i < 8; i++) begin
      r = lfsr(r);
      rx = r[17:16];
      va[i] = r[15:8] | {(i == 4), 7'h00};
      vb[i] = r[7:0] & {(i != 4), 7'h7F};
      acc(2'b01, i[2:0], 1'b1, va[i]);
      acc(2'b10, i[2:0], 1'b1, vb[i]);
    end
    `CHK({pa, pb}, {`DUHB_DIV_BY_4, `DUHB_DIV_BY_1})
    for (int i = 0; i < 8; i++) begin
      acc(2'b01, i[2:0], 1'b0, va[i]);
      acc(2'b10, i[2:0], 1'b0, vb[i]);
    end
    acc(2'b11, 3'h7, 1'b1, 8'h5A);
    acc(2'b01, 3'h7, 1'b0, 8'h5A);
    acc(2'b10, 3'h7, 1'b0, 8'h5A);
    $display("register test done");
    iso = 1'b1;
    acc(2'b01, 3'h7, 1'b1, 8'hA5);
    iso = 1'b0;
    acc(2'b01, 3'h7, 1'b0, 8'h5A);
    $display("isolate test done");
    dev_rst(1'b0, 1'b0);
    acc(2'b01, 3'h7, 1'b0, 8'h00);
    acc(2'b00, 3'h2, 1'b1, 8'hC3);
    acc(2'b10, 3'h2, 1'b1, 8'h3C);
    acc(2'b00, 3'h2, 1'b0, 8'hC3);
    acc(2'b10, 3'h2, 1'b0, 8'h3C);
    `CHK(expq.size(), 0)
    $display("line style test done");
    test_done();
  end
  // Watchdog well past the expected run
  initial begin
    #500000;
    n_mismatch++;
    test_done();
  end
endmodule // tb_dual_uart_host_bus_select
`default_nettype wire
